//--- rtl/dadc_clkdiv.sv
`timescale 1ns/1ps
module dadc_clkdiv (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic [dadc_pkg::SEL_W-1:0] div_sel,
    output logic tick
);
    logic [dadc_pkg::DIV_W-1:0] cnt_reg;
    logic [dadc_pkg::DIV_W-1:0] cnt_next;
    logic [dadc_pkg::DIV_W-1:0] div_w;
    logic [dadc_pkg::DIV_W-1:0] gap_reg;

    assign div_w = dadc_pkg::div_of(div_sel);
    assign tick = ce & run & (cnt_reg == div_w - 7'h01);
    assign cnt_next = (!run || tick) ? 7'h00 : cnt_reg + 7'h01;

    always_ff @(posedge clk) begin
        if (rst)
            cnt_reg <= 7'h00;
        else if (ce)
            cnt_reg <= cnt_next;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !run || tick)
            gap_reg <= 7'h01;
        else if (ce && gap_reg != 7'h7F)
            gap_reg <= gap_reg + 7'h01;
    end

    a_div_period: assert property (@(posedge clk) disable iff (rst)
        (tick && $stable(div_sel) && $past(run) && !$past(tick) && ce)
        |-> (gap_reg == div_w || gap_reg == 7'h7F || !$past(ce)))
        else $error("converter clock period differs from divide ratio");
endmodule : dadc_clkdiv

//--- rtl/dadc_conv_if.sv
`timescale 1ns/1ps
interface dadc_conv_if;
    logic start;
    logic abort;
    logic tick;
    logic comp;
    logic [dadc_pkg::CNT_W-1:0] acq_periods;
    logic busy;
    logic done;
    logic sample_en;
    logic dac_neg;
    logic [dadc_pkg::RES_BITS-1:0] dac_code;
    logic [dadc_pkg::RES_BITS-1:0] mag;
    logic sign;
    modport ctrl (output start, abort, tick, comp, acq_periods,
                  input busy, done, sample_en, dac_neg, dac_code, mag, sign);
    modport eng (input start, abort, tick, comp, acq_periods,
                 output busy, done, sample_en, dac_neg, dac_code, mag, sign);
endinterface : dadc_conv_if

//--- rtl/dadc_pkg.sv
package dadc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL_A = 5'h00;
    localparam logic [4:0] OFS_CTRL_B = 5'h04;
    localparam logic [4:0] OFS_CTRL_C = 5'h08;
    localparam logic [4:0] OFS_RES_HI = 5'h0C;
    localparam logic [4:0] OFS_RES_LO = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int A_EN_BIT = 0;
    localparam int A_GO_BIT = 1;
    localparam int A_POS_LSB = 2;
    localparam int POS_W = 5;
    localparam int B_NEG_LSB = 0;
    localparam int NEG_W = 3;
    localparam int B_REF_LSB = 4;
    localparam int REF_W = 2;
    localparam int B_TRIG_LSB = 6;
    localparam int TRIG_W = 2;
    localparam int C_CS_LSB = 0;
    localparam int C_ACQ_LSB = 3;
    localparam int SEL_W = 3;
    localparam int C_FMT_BIT = 7;
    localparam int ST_SIGN_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int RES_BITS = 12;
    localparam int CNT_W = 5;
    localparam int DIV_W = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [NEG_W-1:0] NEG_GND_CODE = 3'h0;

    // ------------------------------------------------------------
    // Timing tables
    // ------------------------------------------------------------
    // Converter clock divide ratio; the internal-RC codes fall back to /64
    function automatic logic [DIV_W-1:0] div_of(input logic [SEL_W-1:0] sel);
        case (sel)
            3'h0: div_of = 7'h02;
            3'h1: div_of = 7'h08;
            3'h2: div_of = 7'h20;
            3'h4: div_of = 7'h04;
            3'h5: div_of = 7'h10;
            3'h6: div_of = 7'h40;
            default: div_of = 7'h40;
        endcase
    endfunction : div_of

    // Acquisition length in converter clock periods
    function automatic logic [CNT_W-1:0] acq_of(input logic [SEL_W-1:0] sel);
        case (sel)
            3'h0: acq_of = 5'h00;
            3'h1: acq_of = 5'h02;
            3'h2: acq_of = 5'h04;
            3'h3: acq_of = 5'h06;
            3'h4: acq_of = 5'h08;
            3'h5: acq_of = 5'h0C;
            3'h6: acq_of = 5'h10;
            default: acq_of = 5'h14;
        endcase
    endfunction : acq_of
endpackage : dadc_pkg

//--- rtl/dadc_sar.sv
`timescale 1ns/1ps
module dadc_sar (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    dadc_conv_if.eng cv
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_SIGN = 2'b10,
        ST_BITS = 2'b11
    } dadc_sar_st_t;

    localparam int RB = dadc_pkg::RES_BITS;

    function automatic logic [RB-1:0] onehot(input logic [dadc_pkg::CNT_W-1:0] idx);
        onehot = RB'(1) << idx;
    endfunction : onehot

    dadc_sar_st_t state_reg, state_next;
    logic [dadc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [RB-1:0] code_reg, code_next;
    logic sign_reg, sign_next;
    logic done_reg;
    logic keep_w;
    logic last_w;
    logic [dadc_pkg::CNT_W-1:0] acq_seen_reg;
    logic [dadc_pkg::CNT_W-1:0] acq_goal_reg;

    // Comparator high means the difference sits above the trial level
    assign keep_w = cv.comp ^ sign_reg;
    assign last_w = (cnt_reg == 5'h00);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        code_next = code_reg;
        sign_next = sign_reg;
        if (cv.abort) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cv.start) begin
                        cnt_next = cv.acq_periods;
                        code_next = '0;
                        state_next = (cv.acq_periods == 5'h00) ? ST_SIGN : ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (cv.tick) begin
                        cnt_next = cnt_reg - 5'h01;
                        if (cnt_reg == 5'h01)
                            state_next = ST_SIGN;
                    end
                end
                ST_SIGN: begin
                    if (cv.tick) begin
                        sign_next = ~cv.comp;
                        cnt_next = 5'(RB - 1);
                        code_next = onehot(5'(RB - 1));
                        state_next = ST_BITS;
                    end
                end
                ST_BITS: begin
                    if (cv.tick) begin
                        code_next = keep_w ? code_reg : code_reg & ~onehot(cnt_reg);
                        if (last_w) begin
                            state_next = ST_IDLE;
                        end else begin
                            code_next = code_next | onehot(cnt_reg - 5'h01);
                            cnt_next = cnt_reg - 5'h01;
                        end
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 5'h00;
            code_reg <= '0;
            sign_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            code_reg <= code_next;
            sign_reg <= sign_next;
            done_reg <= !cv.abort && state_reg == ST_BITS && cv.tick && last_w;
        end
    end

    assign cv.busy = (state_reg != ST_IDLE);
    assign cv.done = done_reg & ce;
    assign cv.sample_en = (state_reg == ST_ACQ);
    assign cv.dac_neg = sign_reg;
    assign cv.dac_code = code_reg;
    assign cv.mag = code_reg;
    assign cv.sign = sign_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || state_reg != ST_ACQ)
            acq_seen_reg <= 5'h00;
        else if (cv.tick)
            acq_seen_reg <= acq_seen_reg + 5'h01;
    end

    // Length latched at start so a later control write cannot move the goal
    always_ff @(posedge clk) begin
        if (rst)
            acq_goal_reg <= 5'h00;
        else if (cv.start && state_reg == ST_IDLE)
            acq_goal_reg <= cv.acq_periods;
    end

    a_acq_length: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ACQ && cv.tick && cnt_reg == 5'h01 && !cv.abort)
        |-> (acq_seen_reg + 5'h01 == acq_goal_reg))
        else $error("acquisition ended at wrong period count");
    a_acq_exact: assert property (@(posedge clk) disable iff (rst)
        (ce && state_reg == ST_IDLE && cv.start && !cv.abort && cv.acq_periods != 5'h00)
        |=> (cnt_reg == $past(cv.acq_periods)) && (state_reg == ST_ACQ))
        else $error("acquisition not loaded with programmed length");
    a_sign_taken: assert property (@(posedge clk) disable iff (rst)
        (ce && state_reg == ST_SIGN && cv.tick && !cv.abort)
        |=> (sign_reg == !$past(cv.comp)) && (code_reg == onehot(5'(RB - 1))))
        else $error("sign not taken from comparator");
endmodule : dadc_sar

//--- rtl/dadc_top.sv
`timescale 1ns/1ps
module dadc_top #(
    parameter int RES_BITS = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic comp_in,
    input wire logic trig_in,
    output logic [dadc_pkg::POS_W-1:0] pos_channel_sel,
    output logic [dadc_pkg::NEG_W-1:0] neg_channel_sel,
    output logic neg_to_ground,
    output logic [dadc_pkg::REF_W-1:0] reference_sel,
    output logic sample_en,
    output logic [11:0] dac_code,
    output logic dac_negative,
    output logic conv_busy
);
    if (RES_BITS != dadc_pkg::RES_BITS) begin : g_bad_width
        $error("dadc_top serves only the fixed result width");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ack_reg;
    logic req_w;
    logic acc_w;
    logic wr_acc_w;
    logic rd_acc_w;
    logic lane0_w;
    logic [7:0] wbyte_w;
    logic sel_a_w, sel_b_w, sel_c_w, sel_hi_w, sel_lo_w, sel_st_w;

    assign req_w = avs_read | avs_write;
    assign acc_w = req_w & ack_reg & ce;
    assign avs_waitrequest = req_w & ~(ack_reg & ce);
    assign wr_acc_w = acc_w & avs_write;
    assign rd_acc_w = acc_w & avs_read;
    assign lane0_w = avs_byteenable[0];
    assign wbyte_w = avs_writedata[7:0];
    assign sel_a_w = (avs_address == dadc_pkg::OFS_CTRL_A);
    assign sel_b_w = (avs_address == dadc_pkg::OFS_CTRL_B);
    assign sel_c_w = (avs_address == dadc_pkg::OFS_CTRL_C);
    assign sel_hi_w = (avs_address == dadc_pkg::OFS_RES_HI);
    assign sel_lo_w = (avs_address == dadc_pkg::OFS_RES_LO);
    assign sel_st_w = (avs_address == dadc_pkg::OFS_STATUS);

    // One wait state: ack rises the cycle after the request appears
    always_ff @(posedge clk) begin
        if (rst)
            ack_reg <= 1'b0;
        else if (ce)
            ack_reg <= req_w & ~ack_reg;
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_reg, ctrl_b_reg, ctrl_c_reg;
    logic [7:0] ctrl_a_next, ctrl_b_next, ctrl_c_next;
    logic wr_a_w, wr_b_w, wr_c_w;
    logic conv_en_w;
    logic fmt_right_w;
    logic [dadc_pkg::TRIG_W-1:0] trig_sel_w;
    logic [dadc_pkg::SEL_W-1:0] cs_sel_w, acq_sel_w;

    assign wr_a_w = wr_acc_w & lane0_w & sel_a_w;
    assign wr_b_w = wr_acc_w & lane0_w & sel_b_w;
    assign wr_c_w = wr_acc_w & lane0_w & sel_c_w;
    // Go bit is not stored; it reads back as busy
    assign ctrl_a_next = wr_a_w ? (wbyte_w & ~(8'h01 << dadc_pkg::A_GO_BIT)) : ctrl_a_reg;
    assign ctrl_b_next = wr_b_w ? wbyte_w : ctrl_b_reg;
    assign ctrl_c_next = wr_c_w ? (wbyte_w & 8'hBF) : ctrl_c_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_a_reg <= dadc_pkg::CTRL_RST;
            ctrl_b_reg <= dadc_pkg::CTRL_RST;
            ctrl_c_reg <= dadc_pkg::CTRL_RST;
        end else if (ce) begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            ctrl_c_reg <= ctrl_c_next;
        end
    end

    assign conv_en_w = ctrl_a_reg[dadc_pkg::A_EN_BIT];
    assign pos_channel_sel = ctrl_a_reg[dadc_pkg::A_POS_LSB +: dadc_pkg::POS_W];
    assign neg_channel_sel = ctrl_b_reg[dadc_pkg::B_NEG_LSB +: dadc_pkg::NEG_W];
    assign neg_to_ground = (neg_channel_sel == dadc_pkg::NEG_GND_CODE);
    assign reference_sel = ctrl_b_reg[dadc_pkg::B_REF_LSB +: dadc_pkg::REF_W];
    assign trig_sel_w = ctrl_b_reg[dadc_pkg::B_TRIG_LSB +: dadc_pkg::TRIG_W];
    assign cs_sel_w = ctrl_c_reg[dadc_pkg::C_CS_LSB +: dadc_pkg::SEL_W];
    assign acq_sel_w = ctrl_c_reg[dadc_pkg::C_ACQ_LSB +: dadc_pkg::SEL_W];
    assign fmt_right_w = ctrl_c_reg[dadc_pkg::C_FMT_BIT];

    // ------------------------------------------------------------
    // Pin synchronisers and start logic
    // ------------------------------------------------------------
    dadc_conv_if cv ();

    logic [1:0] comp_sync_reg;
    logic [2:0] trig_sync_reg;
    logic trig_edge_w;
    logic go_w;
    logic start_w;

    always_ff @(posedge clk) begin
        if (rst) begin
            comp_sync_reg <= 2'b00;
            trig_sync_reg <= 3'b000;
        end else if (ce) begin
            comp_sync_reg <= {comp_sync_reg[0], comp_in};
            trig_sync_reg <= {trig_sync_reg[1:0], trig_in};
        end
    end

    // Edge taken from stages two and three only
    assign trig_edge_w = trig_sync_reg[1] & ~trig_sync_reg[2] & (trig_sel_w != 2'b00);
    assign go_w = wr_a_w & wbyte_w[dadc_pkg::A_GO_BIT] & wbyte_w[dadc_pkg::A_EN_BIT];
    // Starts are dropped while disabled or mid-conversion
    assign start_w = conv_en_w | go_w ? ((go_w | (trig_edge_w & conv_en_w)) & ~cv.busy) : 1'b0;

    // ------------------------------------------------------------
    // Conversion engine and clock divider
    // ------------------------------------------------------------
    assign cv.start = start_w & ce;
    // Clearing enable aborts; partial results are discarded
    assign cv.abort = ~conv_en_w & ~go_w;
    assign cv.comp = comp_sync_reg[1];
    assign cv.acq_periods = dadc_pkg::acq_of(acq_sel_w);

    dadc_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .run(cv.busy),
        .div_sel(cs_sel_w),
        .tick(cv.tick)
    );

    dadc_sar u_sar (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .cv(cv)
    );

    assign sample_en = cv.sample_en;
    assign dac_code = cv.dac_code;
    assign dac_negative = cv.dac_neg;
    assign conv_busy = cv.busy;

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    logic [RES_BITS-1:0] mag_reg;
    logic sign_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            mag_reg <= '0;
            sign_reg <= 1'b0;
        end else if (ce && cv.done && conv_en_w) begin
            mag_reg <= cv.mag;
            sign_reg <= cv.sign;
        end
    end

    // Left justification puts the top eight bits in the high byte
    function automatic logic [7:0] just_byte(input logic [RES_BITS-1:0] m,
                                             input logic right, input logic hi);
        logic [15:0] w;
        w = right ? {4'h0, m} : {m, 4'h0};
        just_byte = hi ? w[15:8] : w[7:0];
    endfunction : just_byte

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rbyte_w;
    logic [31:0] rdata_reg;

    assign rbyte_w = sel_a_w ? (ctrl_a_reg | ({7'h00, cv.busy} << dadc_pkg::A_GO_BIT)) :
                     sel_b_w ? ctrl_b_reg :
                     sel_c_w ? ctrl_c_reg :
                     sel_hi_w ? just_byte(mag_reg, fmt_right_w, 1'b1) :
                     sel_lo_w ? just_byte(mag_reg, fmt_right_w, 1'b0) :
                     sel_st_w ? {6'h00, cv.busy, sign_reg} : 8'h00;

    always_ff @(posedge clk) begin
        if (rst)
            rdata_reg <= 32'h0000_0000;
        else if (ce && avs_read && !ack_reg)
            rdata_reg <= {24'h000000, rbyte_w};
    end

    assign avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_write_a;
        wr_a_w;
    endsequence
    sequence s_start_seen;
        ce && cv.start;
    endsequence

    a_pos_follow: assert property (s_write_a |=>
        pos_channel_sel == $past(avs_writedata[6:2]))
        else $error("positive select not taken from write");
    a_neg_follow: assert property (wr_b_w |=>
        neg_channel_sel == $past(avs_writedata[2:0]))
        else $error("negative select not taken from write");
    a_gnd_tie: assert property (wr_b_w && avs_writedata[2:0] == 3'h0 |=>
        neg_to_ground && neg_channel_sel == 3'h0)
        else $error("zero negative select does not ground input");
    a_start_busy: assert property (s_start_seen |=> conv_busy)
        else $error("accepted start did not begin conversion");
    a_off_no_start: assert property (!conv_en_w && !go_w && !conv_busy |=>
        !conv_busy)
        else $error("conversion started while disabled");
    a_off_hold: assert property (ce && !conv_en_w |=>
        $stable(mag_reg) && $stable(sign_reg))
        else $error("result changed while disabled");
    a_done_load: assert property (ce && cv.done && conv_en_w |=>
        mag_reg == $past(cv.mag) && sign_reg == $past(cv.sign))
        else $error("result not captured at end of conversion");
    a_right_just: assert property (rd_acc_w && sel_hi_w && fmt_right_w
        && $stable(mag_reg) && $stable(fmt_right_w) |->
        avs_readdata == {28'h0000000, mag_reg[11:8]})
        else $error("right-justified high byte wrong");
    a_ctrl_c_keep: assert property (wr_c_w |=>
        cs_sel_w == $past(avs_writedata[2:0]) && acq_sel_w == $past(avs_writedata[5:3]))
        else $error("control C fields not stored");
    a_bus_wait: assert property (ce && req_w && !ack_reg |-> avs_waitrequest ##1
        (!avs_waitrequest || !ce || !req_w))
        else $error("bus answer not within one wait state");
endmodule : dadc_top

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk, rst, ce, avs_read, avs_write, comp_in, trig_in, tneg;
    logic [4:0] avs_address, pos;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, neg_to_ground, sample_en, dac_negative, conv_busy;
    logic [4:0] pos_channel_sel;
    logic [2:0] neg_channel_sel;
    logic [1:0] reference_sel;
    logic [11:0] dac_code, tgt;
    logic [7:0] ehi, elo;
    logic [31:0] exp_q[$];
    int n_fail = 0, n_checks = 0, seed = 94578, c;
    int cs_t[6] = '{6, 2, 2, 6, 4, 1}, acq_t[6] = '{7, 2, 1, 1, 0, 5};
    int fmt_t[6] = '{1, 0, 1, 0, 1, 0};
    int div_t[6] = '{64, 32, 32, 64, 4, 8}, per_t[6] = '{20, 4, 2, 2, 0, 12};
    dadc_top u_dadc_top (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .comp_in(comp_in), .trig_in(trig_in),
        .pos_channel_sel(pos_channel_sel), .neg_channel_sel(neg_channel_sel),
        .neg_to_ground(neg_to_ground), .reference_sel(reference_sel), .sample_en(sample_en),
        .dac_code(dac_code), .dac_negative(dac_negative), .conv_busy(conv_busy));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // --------------------------------------------------------
    // Comparator stand-in: signed difference tgt, polarity tneg
    // --------------------------------------------------------
    always @(posedge clk) comp_in <= tneg ^ (tgt >= dac_code);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Read data stands through the cycle with waitrequest low
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) check("read queue", 1, 0);
            else check("readdata", avs_readdata, exp_q.pop_front());
        end
    end
    task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d,
                        input logic [3:0] be);
        int k;
        avs_read <= r;
        avs_write <= !r;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        xfer(1'b0, a, d, 4'h1);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        xfer(1'b1, a, 8'h00, 4'h1);
    endtask : rd
    task automatic wait_busy(input logic lvl, input int lim);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (conv_busy !== lvl && c < lim);
        if (conv_busy !== lvl) begin
            n_fail++;
            tally_and_finish();
        end
        @(posedge clk);
    endtask : wait_busy
    initial begin
        {rst, ce, avs_read, avs_write, trig_in, tneg} = 6'b110000;
        {avs_address, avs_writedata, avs_byteenable, tgt} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("neg_to_ground", neg_to_ground, 1);
        rd(dadc_pkg::OFS_CTRL_A, 8'h00);
        rd(dadc_pkg::OFS_CTRL_C, 8'h00);
        rd(5'h18, 8'h00);
        pos = 5'($random(seed));
        wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b00});
        check("pos_channel_sel", pos_channel_sel, pos);
        xfer(1'b0, dadc_pkg::OFS_CTRL_A, 8'hFF, 4'h0);
        rd(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b00});
        for (int n = 0; n < 8; n++) begin
            wr(dadc_pkg::OFS_CTRL_B, {2'b00, 2'(n), 1'b0, 3'(n)});
            check("neg_channel_sel", neg_channel_sel, n);
            check("reference_sel", reference_sel, n % 4);
            check("neg_to_ground", neg_to_ground, n == 0);
        end
        rd(dadc_pkg::OFS_CTRL_B, 8'h37);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            tgt <= 12'($random(seed));
            tneg <= i[0];
            wr(dadc_pkg::OFS_CTRL_C, {1'(fmt_t[i]), 1'b0, 3'(acq_t[i]), 3'(cs_t[i])});
            rd(dadc_pkg::OFS_CTRL_C, {1'(fmt_t[i]), 1'b0, 3'(acq_t[i]), 3'(cs_t[i])});
            wr(dadc_pkg::OFS_CTRL_B, 8'(i));
            wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b11});
            wait_busy(1'b1, 20);
            wait_busy(1'b0, 3000);
            check("busy length", c + 1, (per_t[i] + 13) * div_t[i]);
            ehi = fmt_t[i] ? {4'h0, tgt[11:8]} : tgt[11:4];
            elo = fmt_t[i] ? tgt[7:0] : {tgt[3:0], 4'h0};
            rd(dadc_pkg::OFS_RES_HI, ehi);
            rd(dadc_pkg::OFS_RES_LO, elo);
            rd(dadc_pkg::OFS_STATUS, {7'h00, tneg});
        end
        $display("test conversions done");
        wr(dadc_pkg::OFS_CTRL_B, 8'h40);
        wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b01});
        trig_in <= 1'b1;
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 3000);
        trig_in <= 1'b0;
        rd(dadc_pkg::OFS_STATUS, {7'h00, tneg});
        rd(dadc_pkg::OFS_RES_LO, elo);
        $display("test trigger done");
        wr(dadc_pkg::OFS_CTRL_B, 8'h01);
        tgt <= ~tgt;
        wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b11});
        wait_busy(1'b1, 20);
        repeat (100) @(posedge clk);
        wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b00});
        wait_busy(1'b0, 10);
        wr(dadc_pkg::OFS_CTRL_A, {1'b0, pos, 2'b10});
        repeat (200) @(posedge clk);
        check("conv_busy", conv_busy, 0);
        rd(dadc_pkg::OFS_RES_HI, ehi);
        rd(dadc_pkg::OFS_RES_LO, elo);
        check("queue empty", exp_q.size(), 0);
        $display("test disable done");
        tally_and_finish();
    end
endmodule : tb
